/* File: sim/flash_model.sv */
/*
  flash partner: streams read bytes with a strobe edge for each byte.
  assumes the bench raises go for the length of one read frame.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_model (
  // bench control
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [7:0] first,
  input  wire logic       busy_in,
  // flash pins
  output logic            strobe,
  output logic [7:0]      data,
  output logic            busy
);
  logic [7:0] sent [$];
  logic       half;

  initial begin
    strobe = 1'b0;
    data = 8'h00;
    half = 1'b0;
  end

  // busy flag straight from the bench
  assign busy = busy_in;

  // one byte per two clocks: each strobe level must outlast the pin
  // synchroniser or the edge would never be seen; still outside frames
  always @(posedge aclk) begin
    if (go) begin
      half = ~half;
      if (half) begin
        #2 data = first + 8'(sent.size());
        sent.push_back(data);
        #2 strobe = ~strobe;
      end
    end else begin
      #2 data = ~data; // released bus must not look held
    end
  end
endmodule

`default_nettype wire

/* File: sim/octal_flash_phy_read_capture_tb.sv */
/*
  bench for the read-capture block: axi4-lite master, flash model and a
  queue model of the captured bytes.
  assumes the register map of the package.
*/
`timescale 1ns/1ps
`default_nettype none

module octal_flash_phy_read_capture_tb;
  import flash_capture_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, fdata, first;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        strobe, fbusy, busy_in, go, rd_act, hwp, wrdy, rhold;
  integer      n_fail, compares, cyc, seed, i, k, got;

  octal_flash_phy_read_capture i_octal_flash_phy_read_capture (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_strobe(strobe), .flash_data(fdata), .flash_busy(fbusy),
    .read_active(rd_act), .read_hold(rhold), .write_ready(wrdy),
    .hw_poll_active(hwp));

  flash_model i_flash_model (
    .aclk(aclk), .go(go), .first(first), .busy_in(busy_in),
    .strobe(strobe), .data(fdata), .busy(fbusy));

  // clock, and every input defined at time zero
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, first, busy_in, go, rd_act} = '0;
    wstrb = 4'hf;
    {n_fail, compares, cyc} = '0;
    seed = 61;
    forever #4 aclk = ~aclk;
  end

  // hang guard
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic conclude();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CTRL, d);
    chk(32'(d[2:0]), 32'(CTRL_RESET));
    rd(OFF_CAPTURE, d);
    chk(32'(d[2:0]), 32'(DELAY_RESET));
    rd(8'h10, d);
    chk(32'(r), 32'(RESP_SLVERR));
    // non-phy writes keep hardware polling
    wr(OFF_CTRL, 32'h4);
    @(posedge aclk);
    chk(32'(hwp), 32'h1);
    rd(OFF_STATUS, d);
    chk(32'(d[STAT_HW_POLL]), 32'h1);
    // hardware polling holds writes off while the flash is busy
    busy_in <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(32'(wrdy), 32'h0);
    busy_in <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(32'(wrdy), 32'h1);
    // shifted delay with phy on: polling must drop
    wr(OFF_CAPTURE, 32'h5);
    wr(OFF_CTRL, 32'h5);
    @(posedge aclk);
    chk(32'(hwp), 32'h0);
    // software sees the busy flag both ways
    for (k = 0; k < 2; k++) begin
      busy_in <= k[0];
      repeat (4) @(posedge aclk);
      rd(OFF_STATUS, d);
      chk(32'(d[STAT_BUSY]), 32'(k[0]));
      chk(32'(wrdy), 32'h1);
    end
    busy_in <= 1'b0;
    // capture delay swept over every setting, random first byte counting up
    for (k = 0; k < 8; k++) begin
      wr(OFF_CAPTURE, 32'(k));
      wr(OFF_CTRL, 32'h7);
      i_flash_model.sent.delete();
      first <= 8'($random(seed));
      rd_act <= 1'b1;
      go <= 1'b1;
      repeat (20) @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(posedge aclk);
      rd_act <= 1'b0;
      repeat (8) @(posedge aclk);
      i = 0;
      got = 0;
      // each byte read must match a later sent one, in order; skipped sent bytes are allowed
      do begin
        rd(OFF_DATA, d);
        if (d[DATA_VALID]) begin
          while (i < i_flash_model.sent.size() &&
                 i_flash_model.sent[i] !== d[7:0]) i++;
          chk(32'(i < i_flash_model.sent.size()), 32'h1);
          i++;
          got++;
        end
      end while (d[DATA_VALID] === 1'b1 && got < 24);
      chk(32'(got > 0 && got <= FIFO_DEPTH), 32'h1);
      rd(OFF_STATUS, d);
      chk(32'(d[STAT_LEVEL +: LEVEL_W]), 32'h0);
      chk(32'(rhold), 32'h0);
    end
    wr(OFF_CTRL, 32'h4);
    conclude();
  end
endmodule

`default_nettype wire

/* File: verilog/capture_fifo.sv */
/*
  synchronous fifo with valid/ready on both sides; holds captured bytes.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module capture_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // fill level
  output logic      [CNT_W-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = level != CNT_W'(DEPTH);
  assign out_valid = level != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // storage has no reset; only the pointers and the level need one
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
      level <= level + CNT_W'(push) - CNT_W'(pop);
    end
  end

  fifo_no_overrun_a: assert property (@(posedge aclk) disable iff (!aresetn)
    level == CNT_W'(DEPTH) |-> !in_ready)
    else $error("fifo accepts while full");

endmodule

`default_nettype wire

/* File: verilog/flash_capture_pkg.sv */
/*
  constants for the octal flash read-capture block: register map, field
  positions, reset values and the capture window geometry.
  assumes a 32-bit axi4-lite register bus with 8-bit byte addresses.
*/
`default_nettype none

package flash_capture_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CAPTURE = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_DATA    = 8'h0c;

  // control fields
  localparam int CTRL_PHY_EN   = 0;
  localparam int CTRL_PIPE_RD  = 1;
  localparam int CTRL_HW_POLL  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  // status fields; the two error bits are write-one-to-clear
  localparam int STAT_BUSY     = 0;
  localparam int STAT_HW_POLL  = 1;
  localparam int STAT_WIN_ERR  = 2;
  localparam int STAT_OVERFLOW = 3;
  localparam int STAT_LEVEL    = 8;
  localparam int DATA_VALID    = 8;

  // capture window: delay field width, open width in cycles and reset delay
  localparam int         DELAY_W     = 3;
  localparam logic [2:0] WIN_WIDTH   = 3'h3;
  localparam logic [2:0] DELAY_RESET = 3'h0;

  // fifo geometry
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LEVEL_W    = 5;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* File: verilog/octal_flash_phy_read_capture.sv */
/*
  read-capture and phy-mode control of an octal flash controller: strobe
  or clock based sampling, capture window with tunable delay, busy flag
  handling and an axi4-lite register slave. captured bytes queue in a fifo.
  assumes flash pins are asynchronous to aclk; read_active comes from the
  sequencer on aclk.
*/
// Notes on behaviour
// RQ1: with phy enabled, read bytes are captured on the flash strobe.
// RQ2: strobe captures count only inside the internal-clock sampling window.
// RQ3: host tunes transmit, receive and capture delays for robustness.
// RQ4: a larger capture delay moves the sampling window later.
// RQ5: host enables pipelined phy read mode for reads with shifted delay.
// RQ6: host turns pipelined mode off for writes, separating phases.
// RQ7: with the delay workaround active, hardware busy polling is disabled.
// RQ8: in pipelined phy, writes go as dma within page boundaries.
// RQ9: host polls busy between page writes before the next one.
// RQ10: host may write with phy disabled and hardware polling kept.
// RQ11: tuning sweeps delays and centres within the passing region.
`timescale 1ns/1ps
`default_nettype none

module octal_flash_phy_read_capture (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // flash link pins
  input  wire logic        flash_strobe,
  input  wire logic [7:0]  flash_data,
  input  wire logic        flash_busy,
  // sequencer side
  input  wire logic        read_active,
  output logic             read_hold,
  output logic             write_ready,
  output logic             hw_poll_active
);
  import flash_capture_pkg::*;

  // assertions below share the bus clock and its reset
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [2:0]         ctrl;
  logic [DELAY_W-1:0] cap_delay;
  logic               win_err;
  logic               overflow;
  logic [2:0]         phase;
  logic               window_open;
  logic [9:0]         pin_s1;
  logic [9:0]         pin_s2;
  logic [9:0]         pin_s3;
  logic               strobe_level;
  logic               strobe_edge;
  logic               busy;
  logic               cap_take;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_pop;
  logic [7:0]         fifo_out_data;
  logic [LEVEL_W-1:0] fifo_level;
  logic               aw_held;
  logic               w_held;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               do_write;
  logic               clr_win;
  logic               clr_ovf;
  logic               rd_take;
  logic               phy_en;
  logic               workaround;

  assign phy_en     = ctrl[CTRL_PHY_EN];
  assign workaround = phy_en && (cap_delay != DELAY_RESET);

  // three-stage pin synchronisers: strobe, data byte, busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= {flash_busy, flash_strobe, flash_data};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // a strobe change counts once stages two and three agree
  assign strobe_edge = (pin_s2[8] == pin_s3[8]) && (pin_s3[8] != strobe_level);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_level <= 1'b0;
      busy         <= 1'b0;
    end else begin
      if (pin_s2[8] == pin_s3[8]) begin
        strobe_level <= pin_s3[8];
      end
      if (pin_s2[9] == pin_s3[9]) begin
        busy <= pin_s3[9];
      end
    end
  end

  // internal-clock phase; the window trails phase zero by the delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= '0;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  assign window_open = 3'(phase - cap_delay) < WIN_WIDTH; // RQ2 RQ4

  // strobe capture in phy mode, internal clock edge otherwise
  always_comb begin
    if (phy_en) begin
      cap_take = read_active && strobe_edge && window_open; // RQ1 RQ2
    end else begin
      cap_take = read_active && (phase == 3'h0);
    end
  end

  // full fifo holds the sequencer off; a capture against it is lost
  assign read_hold = !fifo_in_ready;

  capture_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .CNT_W (LEVEL_W)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (cap_take),
    .in_ready  (fifo_in_ready),
    .in_data   (pin_s3[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // hardware busy polling cannot be trusted with a shifted window
  assign hw_poll_active = ctrl[CTRL_HW_POLL] && !workaround; // RQ7
  assign write_ready    = !(hw_poll_active && busy); // RQ10

  // sticky error flags; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_err  <= 1'b0;
      overflow <= 1'b0;
    end else begin
      if (phy_en && read_active && strobe_edge && !window_open) begin
        win_err <= 1'b1; // RQ2
      end else if (clr_win) begin
        win_err <= 1'b0;
      end
      if (cap_take && !fifo_in_ready) begin
        overflow <= 1'b1;
      end else if (clr_ovf) begin
        overflow <= 1'b0;
      end
    end
  end

  // write address and data are taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign clr_win = do_write && aw_addr[7:2] == OFF_STATUS[7:2]
                   && w_strb[0] && w_data[STAT_WIN_ERR];
  assign clr_ovf = do_write && aw_addr[7:2] == OFF_STATUS[7:2]
                   && w_strb[0] && w_data[STAT_OVERFLOW];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr[7:2])
          OFF_CTRL[7:2], OFF_CAPTURE[7:2], OFF_STATUS[7:2]:
            s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and capture-delay registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl      <= CTRL_RESET;
      cap_delay <= DELAY_RESET;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr[7:2] == OFF_CTRL[7:2]) begin
        ctrl <= w_data[2:0];
      end
      if (aw_addr[7:2] == OFF_CAPTURE[7:2]) begin
        cap_delay <= w_data[DELAY_W-1:0]; // RQ4
      end
    end
  end

  // reads answer one cycle after the address; data reads pop the fifo
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign fifo_pop      = rd_take && s_axi_araddr[7:2] == OFF_DATA[7:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      case (s_axi_araddr[7:2])
        OFF_CTRL[7:2]:    s_axi_rdata[2:0] <= ctrl;
        OFF_CAPTURE[7:2]: s_axi_rdata[DELAY_W-1:0] <= cap_delay;
        OFF_STATUS[7:2]: begin
          s_axi_rdata[STAT_BUSY]     <= busy; // RQ9
          s_axi_rdata[STAT_HW_POLL]  <= hw_poll_active;
          s_axi_rdata[STAT_WIN_ERR]  <= win_err;
          s_axi_rdata[STAT_OVERFLOW] <= overflow;
          s_axi_rdata[STAT_LEVEL +: LEVEL_W] <= fifo_level;
        end
        OFF_DATA[7:2]: begin
          s_axi_rdata[DATA_VALID] <= fifo_out_valid;
          s_axi_rdata[7:0]        <= fifo_out_data;
        end
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks; a strobe outside the window must leave a sticky trace
  sequence write_pair_s;
    aw_held && w_held && !s_axi_bvalid;
  endsequence
  sequence late_strobe_s;
    phy_en && read_active && strobe_edge && !window_open;
  endsequence

  strobe_capture_a: assert property (phy_en && cap_take |-> strobe_edge) // RQ1
    else $error("phy capture without strobe edge");
  late_flag_a: assert property (late_strobe_s |=> win_err) // RQ2
    else $error("late strobe not flagged");
  write_resp_a: assert property (write_pair_s |=> s_axi_bvalid)
    else $error("write without response");

endmodule

`default_nettype wire
